// ---- logic/twr_pkg.sv ----
// Package with register map, field positions and reset values of the tuner write bank
package twr_pkg;
	localparam logic [3:0] TWR_OFS_DIV_HIGH = 4'h2;
	localparam logic [3:0] TWR_OFS_DIV_LOW = 4'h3;
	localparam logic [3:0] TWR_OFS_GAIN = 4'h4;
	localparam logic [3:0] TWR_OFS_PUMP_REF = 4'h5;
	localparam logic [3:0] TWR_OFS_FILT_RES = 4'h6;
	localparam logic [3:0] TWR_OFS_PORT1_BW = 4'h7;
	localparam logic [3:0] TWR_OFS_PUMP_CTRL = 4'h8;
	localparam logic [3:0] TWR_OFS_LO_BAND = 4'h9;
	localparam logic [3:0] TWR_OFS_TUNE_RATE = 4'hA;
	localparam logic [3:0] TWR_OFS_WINDOW = 4'hB;
	localparam logic [3:0] TWR_OFS_TEST = 4'hC;
	localparam logic [3:0] TWR_OFS_POWER = 4'hD;
	localparam logic [3:0] TWR_OFS_FIRST = 4'h2;
	localparam logic [3:0] TWR_OFS_LAST = 4'hD;
	localparam int TWR_NUM_REGS = 12;

	localparam logic [7:0] TWR_RST_DIV_HIGH = 8'h00;
	localparam logic [7:0] TWR_RST_DIV_LOW = 8'h00;
	localparam logic [7:0] TWR_RST_GAIN = 8'h80;
	localparam logic [7:0] TWR_RST_PUMP_REF = 8'h00;
	localparam logic [7:0] TWR_RST_FILT_RES = 8'hC0;
	localparam logic [7:0] TWR_RST_PORT1_BW = 8'h20;
	localparam logic [7:0] TWR_RST_PUMP_CTRL = 8'hDB;
	localparam logic [7:0] TWR_RST_LO_BAND = 8'h30;
	localparam logic [7:0] TWR_RST_TUNE_RATE = 8'hE1;
	localparam logic [7:0] TWR_RST_WINDOW_A = 8'h75;
	localparam logic [7:0] TWR_RST_WINDOW_B = 8'hF5;
	localparam logic [7:0] TWR_RST_TEST = 8'hF0;
	localparam logic [7:0] TWR_RST_POWER = 8'h28;

	// Bits that are fixed by hardware, and their fixed value
	localparam logic [7:0] TWR_FIX_MASK_DIV_HIGH = 8'h80;
	localparam logic [7:0] TWR_FIX_MASK_TUNE_RATE = 8'hF8;
	localparam logic [7:0] TWR_FIX_VAL_TUNE_RATE = 8'hE0;

	localparam int TWR_BIT_RF_GAIN = 5;
	localparam int TWR_BIT_PRE_LO = 3;
	localparam int TWR_BIT_POST_LO = 1;
	localparam int TWR_BIT_BYPASS = 0;
	localparam int TWR_BIT_PORT = 7;
	localparam int TWR_BIT_RES_SW = 3;
	localparam int TWR_BIT_PUMP_MODE = 2;
	localparam int TWR_BIT_POWER_DOWN = 7;
	localparam int TWR_BIT_LOGIC_RESET = 1;
	localparam int TWR_BIT_LO_OUT = 0;
endpackage

// ---- logic/twr_ptr_decode.sv ----
// Start register decode from the first data byte of a write
`timescale 1ns/10ps
module twr_ptr_decode
	import twr_pkg::*;
(
	// First data byte
	input wire logic [7:0] first_byte,
	// Selected even register
	output logic [3:0] start_ofs
);
	always_comb begin
		if (!first_byte[7]) begin
			start_ofs = TWR_OFS_DIV_HIGH; // R15
		end else if (!first_byte[6]) begin
			start_ofs = TWR_OFS_GAIN; // R15
		end else begin
			case (first_byte[5:4])
				2'b00: start_ofs = TWR_OFS_FILT_RES; // R15
				2'b01: start_ofs = TWR_OFS_PUMP_CTRL; // R15
				2'b10: start_ofs = TWR_OFS_TUNE_RATE; // R15
				default: start_ofs = TWR_OFS_TEST; // R15
			endcase
		end
	end
endmodule // twr_ptr_decode

// ---- logic/twr_field_map.sv ----
// Splits the register bank into named control fields
`timescale 1ns/10ps
module twr_field_map
	import twr_pkg::*;
(
	// Register image, index 0 is offset 2
	input wire logic [7:0] regs [TWR_NUM_REGS],
	// Synthesizer and gains
	output logic [14:0] div_ratio,
	output logic rf_gain_sel,
	output logic [1:0] prefilter_gain,
	output logic [1:0] postfilter_gain,
	output logic bypass_disable,
	// Pump, reference, ports, filter
	output logic [1:0] switch_ports,
	output logic [1:0] pump_current_sel,
	output logic [4:0] ref_div_sel,
	output logic resistor_switch_off,
	output logic [5:0] bandwidth_code,
	output logic pump_mode,
	// LO tuning
	output logic auto_tune_disable,
	output logic [2:0] main_band_sel,
	output logic [3:0] sub_band_sel,
	output logic [2:0] tune_sample_rate,
	output logic window_select,
	output logic [2:0] window_high_level,
	output logic [2:0] window_low_level,
	output logic window_relax_en,
	// Power and filter reference
	output logic power_down,
	output logic [4:0] filter_ref_sel,
	output logic lo_output_sel
);
	assign div_ratio = {regs[0][6:0], regs[1]}; // R1
	assign rf_gain_sel = regs[2][TWR_BIT_RF_GAIN]; // R3
	assign prefilter_gain = regs[2][TWR_BIT_PRE_LO +: 2]; // R4
	assign postfilter_gain = regs[2][TWR_BIT_POST_LO +: 2]; // R5
	assign bypass_disable = regs[2][TWR_BIT_BYPASS]; // R6
	assign switch_ports = {regs[5][TWR_BIT_PORT], regs[3][TWR_BIT_PORT]}; // R8 R13
	assign pump_current_sel = regs[3][6:5]; // R8
	assign ref_div_sel = regs[3][4:0]; // R8
	assign resistor_switch_off = regs[4][TWR_BIT_RES_SW]; // R13
	assign bandwidth_code = regs[5][6:1]; // R13
	assign pump_mode = regs[6][TWR_BIT_PUMP_MODE]; // R13
	assign auto_tune_disable = regs[7][7]; // R9
	assign main_band_sel = regs[7][6:4]; // R9
	assign sub_band_sel = regs[7][3:0]; // R9
	assign tune_sample_rate = regs[8][2:0]; // R10
	assign window_select = regs[9][7]; // R11
	assign window_high_level = regs[9][6:4]; // R11
	assign window_low_level = regs[9][3:1]; // R11
	assign window_relax_en = regs[9][0]; // R11
	assign power_down = regs[11][TWR_BIT_POWER_DOWN]; // R12
	assign filter_ref_sel = regs[11][6:2]; // R12
	assign lo_output_sel = regs[11][TWR_BIT_LO_OUT]; // R12
endmodule // twr_field_map

// ---- logic/twr_bank.sv ----
// Tuner write register bank loaded byte by byte from the serial slave
//
// Contract
// R1: 15-bit division ratio in bytes 2 and 3, byte 2 bit 7 zero, reset zero.
// R2: Controller computes ratio as frequency over comparison step; not checked here.
// R3: RF gain select at byte 4 bit 5, reset zero.
// R4: Pre-filter gain at byte 4 bits 4..3, reset 00.
// R5: Post-filter gain at byte 4 bits 2..1, reset 00.
// R6: Bypass disable at byte 4 bit 0, reset zero keeps bypass on.
// R7: Power-on defaults loaded into every byte as tabulated.
// R8: Byte 5 holds port 0, pump current and reference divider; resets zero.
// R9: Byte 9 holds tuning disable, main band, sub-band; resets 0x30.
// R10: Byte 10 has fixed 11100 high bits, sample rate low; resets 0xE1.
// R11: Byte 11 holds window fields; reset 0x75 or 0xF5 by parameter.
// R12: Byte 13 holds power-down, filter reference, logic reset, LO output.
// R13: Byte 6 resistor switch, byte 7 port 1 and bandwidth, byte 8 pump mode.
// R14: Pointer advances after every accepted data byte before byte 13; after byte 13 it stays at 13.
// R15: First data byte selects the starting even register from its upper bits.
// R16: Bytes beyond byte 13 are ignored.
// R17: Logic reset bit restores bytes 7, 9-13 then clears itself; zero no effect.
`timescale 1ns/10ps
module twr_bank
	import twr_pkg::*;
#(
	parameter logic [7:0] WINDOW_RESET = TWR_RST_WINDOW_A
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Byte stream from the serial slave
	input wire logic wr_start,
	input wire logic wr_valid,
	input wire logic [7:0] wr_data,
	// Decoded fields
	output logic [14:0] div_ratio,
	output logic rf_gain_sel,
	output logic [1:0] prefilter_gain,
	output logic [1:0] postfilter_gain,
	output logic bypass_disable,
	output logic [1:0] switch_ports,
	output logic [1:0] pump_current_sel,
	output logic [4:0] ref_div_sel,
	output logic resistor_switch_off,
	output logic [5:0] bandwidth_code,
	output logic pump_mode,
	output logic auto_tune_disable,
	output logic [2:0] main_band_sel,
	output logic [3:0] sub_band_sel,
	output logic [2:0] tune_sample_rate,
	output logic window_select,
	output logic [2:0] window_high_level,
	output logic [2:0] window_low_level,
	output logic window_relax_en,
	output logic power_down,
	output logic [4:0] filter_ref_sel,
	output logic lo_output_sel,
	// Pointer state
	output logic wr_idle,
	output logic [3:0] wr_ptr
);
	if (WINDOW_RESET != TWR_RST_WINDOW_A && WINDOW_RESET != TWR_RST_WINDOW_B) begin : g_window_check
		$error("WINDOW_RESET must be 8'h75 or 8'hF5");
	end

	typedef enum logic [1:0] {
		TWR_IDLE,
		TWR_WAIT_FIRST,
		TWR_STREAM,
		TWR_DONE
	} twr_state_e;

	typedef struct packed {
		twr_state_e state;
		logic [3:0] ptr;
		logic [TWR_NUM_REGS-1:0][7:0] regs;
	} twr_state_s;

	twr_state_s st_reg;
	twr_state_s st_next;
	logic [3:0] start_ofs;
	logic [7:0] reg_view [TWR_NUM_REGS];

	// Reset image, index 0 is offset 2
	function automatic logic [7:0] reset_of(input int idx);
		case (idx)
			0: reset_of = TWR_RST_DIV_HIGH;
			1: reset_of = TWR_RST_DIV_LOW;
			2: reset_of = TWR_RST_GAIN;
			3: reset_of = TWR_RST_PUMP_REF;
			4: reset_of = TWR_RST_FILT_RES;
			5: reset_of = TWR_RST_PORT1_BW;
			6: reset_of = TWR_RST_PUMP_CTRL;
			7: reset_of = TWR_RST_LO_BAND;
			8: reset_of = TWR_RST_TUNE_RATE;
			9: reset_of = WINDOW_RESET;
			10: reset_of = TWR_RST_TEST;
			default: reset_of = TWR_RST_POWER;
		endcase
	endfunction

	// Registers hit by the logic reset bit
	function automatic logic cleared_by_logic_reset(input int idx);
		cleared_by_logic_reset = (idx == 5) || (idx >= 7);
	endfunction

	// Fixed bits cannot be overwritten
	function automatic logic [7:0] fix_bits(input int idx, input logic [7:0] val);
		if (idx == 0) begin
			fix_bits = val & ~TWR_FIX_MASK_DIV_HIGH; // R1
		end else if (idx == 8) begin
			fix_bits = (val & ~TWR_FIX_MASK_TUNE_RATE) | TWR_FIX_VAL_TUNE_RATE; // R10
		end else begin
			fix_bits = val;
		end
	endfunction

	twr_ptr_decode twr_ptr_decode_i (
		.first_byte(wr_data),
		.start_ofs(start_ofs)
	);

	always_comb begin
		logic [3:0] tgt;
		logic hit;
		logic [7:0] wval;
		tgt = 4'h0;
		hit = 1'b0;
		wval = 8'h00;
		st_next = st_reg;
		case (st_reg.state)
			TWR_IDLE: begin
				if (wr_start) begin
					st_next.state = TWR_WAIT_FIRST;
				end
			end
			TWR_WAIT_FIRST: begin
				if (wr_valid) begin
					tgt = start_ofs; // R15
					hit = 1'b1;
				end
			end
			TWR_STREAM: begin
				if (wr_valid) begin
					tgt = st_reg.ptr;
					hit = 1'b1;
				end
			end
			TWR_DONE: begin
				// Past byte 13; drop data until a new start
			end
			default: st_next.state = TWR_IDLE;
		endcase
		if (wr_start) begin
			st_next.state = TWR_WAIT_FIRST;
		end else if (hit) begin
			if (tgt == TWR_OFS_LAST) begin
				st_next.state = TWR_DONE; // R16
			end else begin
				st_next.state = TWR_STREAM;
				st_next.ptr = tgt + 4'h1; // R14
			end
			wval = fix_bits(int'(tgt - TWR_OFS_FIRST), wr_data);
			if (tgt == TWR_OFS_POWER && wr_data[TWR_BIT_LOGIC_RESET]) begin
				for (int i = 0; i < TWR_NUM_REGS; i++) begin
					if (cleared_by_logic_reset(i)) begin
						st_next.regs[i] = reset_of(i); // R17
					end
				end
				st_next.regs[TWR_NUM_REGS-1][TWR_BIT_LOGIC_RESET] = 1'b0; // R17
			end else begin
				st_next.regs[tgt - TWR_OFS_FIRST] = wval; // R14
			end
		end
		if (rst) begin
			st_next.state = TWR_IDLE;
			st_next.ptr = TWR_OFS_FIRST;
			for (int i = 0; i < TWR_NUM_REGS; i++) begin
				st_next.regs[i] = reset_of(i); // R7
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		st_reg <= st_next;
	end

	generate
		for (genvar g = 0; g < TWR_NUM_REGS; g++) begin : g_view
			assign reg_view[g] = st_reg.regs[g];
		end
	endgenerate

	twr_field_map twr_field_map_i (
		.regs(reg_view),
		.div_ratio(div_ratio),
		.rf_gain_sel(rf_gain_sel),
		.prefilter_gain(prefilter_gain),
		.postfilter_gain(postfilter_gain),
		.bypass_disable(bypass_disable),
		.switch_ports(switch_ports),
		.pump_current_sel(pump_current_sel),
		.ref_div_sel(ref_div_sel),
		.resistor_switch_off(resistor_switch_off),
		.bandwidth_code(bandwidth_code),
		.pump_mode(pump_mode),
		.auto_tune_disable(auto_tune_disable),
		.main_band_sel(main_band_sel),
		.sub_band_sel(sub_band_sel),
		.tune_sample_rate(tune_sample_rate),
		.window_select(window_select),
		.window_high_level(window_high_level),
		.window_low_level(window_low_level),
		.window_relax_en(window_relax_en),
		.power_down(power_down),
		.filter_ref_sel(filter_ref_sel),
		.lo_output_sel(lo_output_sel)
	);

	assign wr_idle = (st_reg.state == TWR_IDLE);
	assign wr_ptr = st_reg.ptr;
endmodule // twr_bank

// ---- sim/twr_bank_chk.sv ----
// Port assertions for the tuner write register bank
`timescale 1ns/10ps
module twr_bank_chk
	import twr_pkg::*;
#(
	parameter logic [7:0] WINDOW_RESET = TWR_RST_WINDOW_A
)
(
	// Clock, reset and byte stream
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic wr_start,
	input wire logic wr_valid,
	input wire logic [7:0] wr_data,
	// Watched outputs
	input wire logic [14:0] div_ratio,
	input wire logic [1:0] prefilter_gain,
	input wire logic [1:0] switch_ports,
	input wire logic [5:0] bandwidth_code,
	input wire logic [2:0] main_band_sel,
	input wire logic [2:0] tune_sample_rate,
	input wire logic window_select,
	input wire logic power_down,
	input wire logic [4:0] filter_ref_sel,
	input wire logic lo_output_sel,
	input wire logic wr_idle,
	input wire logic [3:0] wr_ptr
);
	logic first_reg;
	logic done_reg;
	logic take;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// First byte is decoded, so it must not count as a pointer step
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			first_reg <= 1'b0;
		end else if (wr_start) begin
			first_reg <= 1'b1;
		end else if (wr_valid) begin
			first_reg <= 1'b0;
		end
	end
	// Byte 13 closes the write; pointer stays at 13, so later bytes must not count
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			done_reg <= 1'b0;
		end else if (wr_start) begin
			done_reg <= 1'b0;
		end else if (take && wr_ptr == 4'hD) begin
			done_reg <= 1'b1;
		end
	end
	assign take = wr_valid && !wr_start && !wr_idle && !first_reg && !done_reg;
	property p_reset;
		$fell(rst) |-> wr_idle && wr_ptr == 4'h2 && div_ratio == 15'h0000 && filter_ref_sel == 5'h0A;
	endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong");
	property p_first_div;
		first_reg && wr_valid && !wr_start && !wr_data[7] |=>
			div_ratio[14:8] == $past(wr_data[6:0]) && wr_ptr == 4'h3;
	endproperty
	a_first_div: assert property (p_first_div) else $error("divider start wrong");
	property p_first_gain;
		first_reg && wr_valid && !wr_start && wr_data[7:6] == 2'b10 |=>
			prefilter_gain == $past(wr_data[4:3]) && wr_ptr == 4'h5;
	endproperty
	a_first_gain: assert property (p_first_gain) else $error("gain start wrong");
	property p_advance;
		take && wr_ptr < 4'hD |=> wr_ptr == $past(wr_ptr) + 4'h1;
	endproperty
	a_advance: assert property (p_advance) else $error("pointer did not advance");
	property p_idle_hold;
		wr_idle && !wr_start |=> $stable(div_ratio) && $stable(bandwidth_code) && $stable(power_down);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("idle byte changed bank");
	property p_past_last;
		take && wr_ptr == 4'hD ##1 wr_valid && !wr_start |=> $stable(filter_ref_sel) && $stable(div_ratio);
	endproperty
	a_past_last: assert property (p_past_last) else $error("byte past last stored");
	property p_byte13;
		take && wr_ptr == 4'hD && !wr_data[1] |=> power_down == $past(wr_data[7]) &&
			filter_ref_sel == $past(wr_data[6:2]) && lo_output_sel == $past(wr_data[0]);
	endproperty
	a_byte13: assert property (p_byte13) else $error("power byte wrong");
	property p_clear;
		take && wr_ptr == 4'hD && wr_data[1] |=> filter_ref_sel == 5'h0A && bandwidth_code == 6'h10
			&& !switch_ports[1] && main_band_sel == 3'h3 && tune_sample_rate == 3'h1
			&& window_select == WINDOW_RESET[7];
	endproperty
	a_clear: assert property (p_clear) else $error("logic reset wrong");
	property p_rate;
		take && wr_ptr == 4'hA |=> tune_sample_rate == $past(wr_data[2:0]);
	endproperty
	a_rate: assert property (p_rate) else $error("sample rate wrong");
endmodule // twr_bank_chk

bind twr_bank twr_bank_chk #(.WINDOW_RESET(WINDOW_RESET)) twr_bank_chk_i (.*);

// ---- sim/twr_host_model.sv ----
// Byte stream master standing in for the serial bus front end
`timescale 1ns/10ps
module twr_host_model (
	// Clock
	input wire logic sys_clk,
	// Byte stream
	output logic wr_start,
	output logic wr_valid,
	output logic [7:0] wr_data
);
	initial begin
		wr_start = 1'b0;
		wr_valid = 1'b0;
		wr_data = 8'h00;
	end
	function automatic logic [14:0] ratio_of(input int f_khz, input int step_khz);
		return 15'(f_khz / step_khz);
	endfunction
	// Opens a write and streams bytes back to back
	task automatic send(input logic [7:0] q[$]);
		@(negedge sys_clk);
		wr_start = 1'b1;
		foreach (q[i]) begin
			@(negedge sys_clk);
			wr_start = 1'b0;
			wr_valid = 1'b1;
			wr_data = q[i];
		end
		@(negedge sys_clk);
		wr_valid = 1'b0;
		// Released data must not keep looking valid
		wr_data = ~wr_data;
	endtask
	task automatic stray(input logic [7:0] b);
		@(negedge sys_clk);
		wr_valid = 1'b1;
		wr_data = b;
		@(negedge sys_clk);
		wr_valid = 1'b0;
		wr_data = ~b;
	endtask
endmodule // twr_host_model

// ---- sim/twr_bank_bench.sv ----
// Self-checking bench for the tuner write register bank
`timescale 1ns/10ps
module twr_bank_bench;
	import twr_pkg::*;
	localparam logic [7:0] WR = TWR_RST_WINDOW_A;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic wr_start, wr_valid, wr_idle, rf_gain_sel, bypass_disable, resistor_switch_off;
	logic pump_mode, auto_tune_disable, window_select, window_relax_en, power_down, lo_output_sel;
	logic [1:0] prefilter_gain, postfilter_gain, switch_ports, pump_current_sel;
	logic [2:0] main_band_sel, tune_sample_rate, window_high_level, window_low_level;
	logic [3:0] sub_band_sel, wr_ptr;
	logic [4:0] ref_div_sel, filter_ref_sel;
	logic [5:0] bandwidth_code;
	logic [7:0] wr_data;
	logic [14:0] div_ratio;
	int fail_count = 0;
	int cmp_count = 0;
	twr_host_model twr_host_model_i (.*);
	twr_bank #(.WINDOW_RESET(WR)) twr_bank_i (.*);
	always #50 sys_clk = ~sys_clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic t_defaults();
		chk(div_ratio, 15'h0000);
		chk({rf_gain_sel, prefilter_gain, postfilter_gain, bypass_disable}, 6'h00);
		chk({switch_ports, pump_current_sel, ref_div_sel}, 9'h000);
		chk({resistor_switch_off, bandwidth_code, pump_mode}, 8'h20);
		chk({auto_tune_disable, main_band_sel, sub_band_sel}, 8'h30);
		chk(tune_sample_rate, 3'h1);
		chk({window_select, window_high_level, window_low_level, window_relax_en}, WR);
		chk({power_down, filter_ref_sel, lo_output_sel}, 7'h14);
		chk({wr_idle, wr_ptr}, 5'h12);
		twr_host_model_i.stray(8'h7F);
		chk({wr_idle, div_ratio}, 16'h8000);
	endtask
	task automatic t_divider();
		logic [14:0] n;
		n = twr_host_model_i.ratio_of(2150000, 125);
		twr_host_model_i.send('{{1'b0, n[14:8]}, n[7:0]});
		chk(div_ratio, n);
	endtask
	task automatic t_gain();
		logic [7:0] v;
		logic [7:0] w;
		for (int i = 0; i < 4; i++) begin
			v = {2'b10, i[1], i[1:0], 2'(3 - i), i[0]};
			w = {i[0], i[1:0], 5'(i * 9)};
			twr_host_model_i.send('{v, w});
			chk({rf_gain_sel, prefilter_gain, postfilter_gain, bypass_disable}, v[5:0]);
			chk({switch_ports[0], pump_current_sel, ref_div_sel}, w);
		end
	endtask
	task automatic t_chain();
		twr_host_model_i.send('{8'hC8, 8'hBE, 8'hDF, 8'hC5, 8'h06, 8'hAA, 8'hF0, 8'hA9, 8'h00});
		chk({resistor_switch_off, switch_ports[1], bandwidth_code, pump_mode}, 9'h1BF);
		chk({auto_tune_disable, main_band_sel, sub_band_sel}, 8'hC5);
		chk(tune_sample_rate, 3'h6);
		chk({window_select, window_high_level, window_low_level, window_relax_en}, 8'hAA);
		chk({power_down, filter_ref_sel, lo_output_sel}, 7'h55);
		twr_host_model_i.stray(8'hFF);
		chk({power_down, filter_ref_sel, lo_output_sel}, 7'h55);
	endtask
	task automatic t_clear();
		twr_host_model_i.send('{8'hD0});
		chk(pump_mode, 1'b0);
		twr_host_model_i.send('{8'hE2});
		chk(tune_sample_rate, 3'h2);
		twr_host_model_i.send('{8'hF0, 8'h02});
		chk({switch_ports[1], bandwidth_code}, 7'h10);
		chk({auto_tune_disable, main_band_sel, sub_band_sel, tune_sample_rate}, 11'h181);
		chk({window_select, window_high_level, window_low_level, window_relax_en}, WR);
		chk({power_down, filter_ref_sel, lo_output_sel}, 7'h14);
		chk({resistor_switch_off, pump_mode, switch_ports[0]}, 3'b101);
	endtask
	// Mid-run reset must also restore the bytes that logic reset leaves alone
	task automatic t_reset();
		rst = 1'b1;
		repeat (2) @(negedge sys_clk);
		rst = 1'b0;
		t_defaults();
	endtask
	initial begin
		repeat (5) @(negedge sys_clk);
		rst = 1'b0;
		t_defaults();
		t_divider();
		t_gain();
		t_chain();
		t_clear();
		t_reset();
		stop_test();
	end
	// About twenty times the expected run
	initial begin
		#100000;
		fail_count++;
		stop_test();
	end
endmodule // twr_bank_bench
